// ---- frs_pkg.sv ----
package frs_pkg;
    localparam int          FRS_NREG       = 8;
    localparam int          FRS_PTR_W      = 3;
    localparam int          FRS_DATA_W     = 80;
    localparam int          FRS_MEM_W      = 80;
    localparam int          FRS_MMX_W      = 64;
    localparam int          FRS_FMT_W      = 3;
    localparam int          FRS_OP_W       = 4;
    localparam logic [2:0]  FRS_TOP_RST    = 3'h0;
    localparam logic [7:0]  FRS_TAG_RST    = 8'h00;
    localparam logic [15:0] FRS_CTRL_RST   = 16'h037f;
    localparam logic [15:0] FRS_STAT_RST   = 16'h0000;
    localparam int          FRS_TOP_LSB    = 11;
    localparam int          FRS_C1_BIT     = 9;
    localparam int          FRS_SF_BIT     = 6;
    localparam int          FRS_IE_BIT     = 0;
    localparam int          FRS_ES_BIT     = 7;
    localparam int          FRS_B_BIT      = 15;
    localparam logic [14:0] FRS_EXP_BIAS   = 15'h3fff;
    localparam logic [14:0] FRS_EXP_MAX    = 15'h7fff;
    localparam logic [10:0] FRS_D_BIAS     = 11'h3ff;

    typedef enum logic [2:0] {
        FRS_FMT_EXT,
        FRS_FMT_DBL,
        FRS_FMT_INT64,
        FRS_FMT_BCD
    } frs_fmt_t;

    typedef enum logic [3:0] {
        FRS_OP_NONE,
        FRS_OP_LOAD_PUSH,
        FRS_OP_LOAD_KEEP,
        FRS_OP_STORE_POP,
        FRS_OP_STORE_KEEP,
        FRS_OP_EXCH,
        FRS_OP_WRITE_REL,
        FRS_OP_INIT,
        FRS_OP_MMX_WRITE,
        FRS_OP_CALL_RET,
        FRS_OP_CLEAR_EXC
    } frs_op_t;
endpackage

// ---- frs_regmem.sv ----
`timescale 1ns/1ps
`default_nettype none
module frs_regmem
    import frs_pkg::*;
#(
    parameter int DEPTH = FRS_NREG,
    parameter int WIDTH = FRS_DATA_W,
    parameter int AW    = FRS_PTR_W
) (
    input  wire logic             clk_i,
    input  wire logic             we_a_i,
    input  wire logic [AW-1:0]    wa_a_i,
    input  wire logic [WIDTH-1:0] wd_a_i,
    input  wire logic             we_b_i,
    input  wire logic [AW-1:0]    wa_b_i,
    input  wire logic [WIDTH-1:0] wd_b_i,
    input  wire logic [AW-1:0]    ra_a_i,
    input  wire logic [AW-1:0]    ra_b_i,
    output logic      [WIDTH-1:0] rd_a_o,
    output logic      [WIDTH-1:0] rd_b_o
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] rd_a_r;
    logic [WIDTH-1:0] rd_b_r;

    // port b wins a same-address collision; top issues one only for an exchange with index zero
    always_ff @(posedge clk_i) begin
        if (we_a_i) begin
            mem_r[wa_a_i] <= wd_a_i;
        end
        if (we_b_i) begin
            mem_r[wa_b_i] <= wd_b_i;
        end
        rd_a_r <= mem_r[ra_a_i];
        rd_b_r <= mem_r[ra_b_i];
    end

    assign rd_a_o = rd_a_r;
    assign rd_b_o = rd_b_r;
endmodule // frs_regmem
`default_nettype wire

// ---- frs_stack.sv ----
`timescale 1ns/1ps
`default_nettype none
module frs_stack
    import frs_pkg::*;
(
    input  wire logic                  CORE_CLK_I,
    input  wire logic                  RSTN_I,
    input  wire logic                  OP_VALID_I,
    input  wire logic [FRS_OP_W-1:0]   OP_CODE_I,
    input  wire logic [FRS_FMT_W-1:0]  OP_FMT_I,
    input  wire logic [FRS_PTR_W-1:0]  OP_IDX_I,
    input  wire logic [FRS_MEM_W-1:0]  OP_DATA_I,
    input  wire logic [10:0]           OP_OPCODE_I,
    input  wire logic [47:0]           OP_IP_I,
    input  wire logic [47:0]           OP_DP_I,
    output logic      [FRS_MEM_W-1:0]  STORE_DATA_O,
    output logic                       STORE_VALID_O,
    output logic                       STACK_FAULT_O,
    output logic      [15:0]           STATUS_WORD_O,
    output logic      [15:0]           CTRL_WORD_O,
    output logic      [7:0]            TAG_BITS_O,
    output logic      [47:0]           LAST_IP_O,
    output logic      [47:0]           LAST_DP_O,
    output logic      [10:0]           LAST_OPCODE_O,
    output logic      [FRS_DATA_W-1:0] REL_DATA_O
);
    // status word kept whole; pointer field is overlaid from top_r
    typedef enum logic [1:0] {FRS_PEND_IDLE, FRS_PEND_STORE, FRS_PEND_EXCH} frs_pend_t;
    logic [FRS_PTR_W-1:0] top_r,   top_nxt;
    logic [7:0]           tag_r,   tag_nxt;
    logic [15:0]          stat_r,  stat_nxt;
    logic [47:0]          ip_r,    ip_nxt;
    logic [47:0]          dp_r,    dp_nxt;
    logic [10:0]          opc_r,   opc_nxt;
    logic                 sv_r,    sv_nxt;
    logic                 flt_r,   flt_nxt;
    frs_pend_t            pend_r,  pend_nxt;
    logic [FRS_FMT_W-1:0] pfmt_r,  pfmt_nxt;
    logic [FRS_MEM_W-1:0] sd_r,    sd_nxt;
    logic                  we_a, we_b;
    logic [FRS_PTR_W-1:0]  wa_a, wa_b, ra_a, ra_b;
    logic [FRS_DATA_W-1:0] wd_a, wd_b, rd_a, rd_b;
    function automatic logic [FRS_PTR_W-1:0] rel_addr(input logic [FRS_PTR_W-1:0] top,
                                                      input logic [FRS_PTR_W-1:0] idx);
        rel_addr = top + idx;
    endfunction
    // simple int64 -> extended; exact since extended has a 64-bit mantissa
    function automatic logic [79:0] int_to_ext(input logic [63:0] v);
        logic [63:0] mag;
        logic [14:0] e;
        int          i;
        mag = v[63] ? (~v + 64'h1) : v;
        e   = 15'h0;
        int_to_ext = 80'h0;
        if (mag != 64'h0) begin
            for (i = 0; i < 64; i++) begin
                if (mag[i]) begin
                    e = FRS_EXP_BIAS + 15'(i);
                end
            end
            int_to_ext = {v[63], e, mag << (15'd63 - (e - FRS_EXP_BIAS))};
        end
    endfunction
    function automatic logic [63:0] bcd_to_int(input logic [79:0] b);
        logic [63:0] acc;
        int          i;
        acc = 64'h0;
        for (i = 17; i >= 0; i--) begin
            acc = acc * 64'd10 + 64'(b[i*4 +: 4]);
        end
        bcd_to_int = b[79] ? (~acc + 64'h1) : acc;
    endfunction
    function automatic logic [79:0] load_conv(input logic [FRS_FMT_W-1:0] f,
                                              input logic [79:0] d);
        case (f)
            FRS_FMT_DBL: begin
                if (d[62:52] == 11'h0) begin
                    load_conv = {d[63], 79'h0}; // denormals flush to zero
                end else if (d[62:52] == 11'h7ff) begin
                    load_conv = {d[63], FRS_EXP_MAX, 1'b1, d[51:0], 11'h0};
                end else begin
                    load_conv = {d[63], 15'(d[62:52]) - 15'(FRS_D_BIAS) + FRS_EXP_BIAS, 1'b1, d[51:0], 11'h0};
                end
            end
            FRS_FMT_INT64: load_conv = int_to_ext(d[63:0]);
            FRS_FMT_BCD:   load_conv = int_to_ext(bcd_to_int(d));
            default:       load_conv = d;
        endcase
    endfunction
    // store conversion truncates toward zero; rounding modes are not modelled
    function automatic logic [79:0] store_conv(input logic [FRS_FMT_W-1:0] f,
                                               input logic [79:0] x);
        logic [14:0] e;
        logic [63:0] mag;
        logic [63:0] q;
        logic [71:0] bcd;
        int          i;
        e   = x[78:64];
        mag = 64'h0;
        bcd = 72'h0;
        if (e >= FRS_EXP_BIAS && e < FRS_EXP_BIAS + 15'd63) begin
            mag = x[63:0] >> (15'd63 - (e - FRS_EXP_BIAS));
        end
        q = mag;
        for (i = 0; i < 18; i++) begin
            bcd[i*4 +: 4] = 4'(q % 64'd10);
            q = q / 64'd10;
        end
        case (f)
            FRS_FMT_DBL: begin
                if (e == 15'h0) begin
                    store_conv = {16'h0, x[79], 63'h0};
                end else if (e == FRS_EXP_MAX) begin
                    store_conv = {16'h0, x[79], 11'h7ff, x[62:11]};
                end else begin
                    store_conv = {16'h0, x[79], 11'(e - FRS_EXP_BIAS + 15'(FRS_D_BIAS)), x[62:11]};
                end
            end
            FRS_FMT_INT64: store_conv = {16'h0, x[79] ? (~mag + 64'h1) : mag};
            FRS_FMT_BCD:   store_conv = {x[79], 7'h0, bcd};
            default:       store_conv = x;
        endcase
    endfunction
    // eight 80-bit registers in one memory
    frs_regmem #(
        .DEPTH (FRS_NREG),
        .WIDTH (FRS_DATA_W),
        .AW    (FRS_PTR_W)
    ) u_mem (
        .clk_i  (CORE_CLK_I),
        .we_a_i (we_a),
        .wa_a_i (wa_a),
        .wd_a_i (wd_a),
        .we_b_i (we_b),
        .wa_b_i (wa_b),
        .wd_b_i (wd_b),
        .ra_a_i (ra_a),
        .ra_b_i (ra_b),
        .rd_a_o (rd_a),
        .rd_b_o (rd_b)
    );
    // a store or exchange holds the port one more cycle; its read data lands then
    always_comb begin
        top_nxt  = top_r;
        tag_nxt  = tag_r;
        stat_nxt = stat_r;
        ip_nxt   = ip_r;
        dp_nxt   = dp_r;
        opc_nxt  = opc_r;
        sv_nxt   = 1'b0;
        flt_nxt  = 1'b0;
        pend_nxt = FRS_PEND_IDLE;
        pfmt_nxt = pfmt_r;
        sd_nxt   = sd_r;
        we_a     = 1'b0;
        we_b     = 1'b0;
        wa_a     = top_r;
        wa_b     = top_r;
        wd_a     = rd_b;
        wd_b     = rd_a;
        ra_a     = top_r;
        ra_b     = top_r;
        case (pend_r)
            FRS_PEND_STORE: begin
                sv_nxt = 1'b1;
                sd_nxt = store_conv(pfmt_r, rd_a);
            end
            FRS_PEND_EXCH: begin
                we_a = 1'b1; // head gets the other entry
                we_b = 1'b1;
                wa_b = rel_addr(top_r, pfmt_r);
            end
            default: sv_nxt = 1'b0;
        endcase
        // one operation per valid cycle from the issue logic, none while a store or exchange is pending
        if (OP_VALID_I && pend_r == FRS_PEND_IDLE) begin
            opc_nxt = OP_OPCODE_I;
            ip_nxt  = OP_IP_I;
            dp_nxt  = OP_DP_I;
            ra_b    = rel_addr(top_r, OP_IDX_I);
            case (OP_CODE_I)
                FRS_OP_LOAD_PUSH: begin
                    top_nxt = top_r - 3'h1;
                    we_a    = 1'b1;
                    wa_a    = top_r - 3'h1;
                    wd_a    = load_conv(OP_FMT_I, OP_DATA_I);
                    tag_nxt[top_r - 3'h1] = 1'b1;
                    if (tag_r[top_r - 3'h1]) begin
                        flt_nxt = 1'b1;
                        stat_nxt[FRS_IE_BIT] = 1'b1;
                        stat_nxt[FRS_SF_BIT] = 1'b1;
                        stat_nxt[FRS_C1_BIT] = 1'b1;
                    end
                end
                FRS_OP_LOAD_KEEP, FRS_OP_WRITE_REL: begin
                    we_a = 1'b1;
                    wa_a = rel_addr(top_r, OP_IDX_I);
                    wd_a = load_conv(OP_FMT_I, OP_DATA_I);
                    tag_nxt[rel_addr(top_r, OP_IDX_I)] = 1'b1;
                end
                FRS_OP_STORE_POP, FRS_OP_STORE_KEEP: begin
                    ra_a     = (OP_CODE_I == FRS_OP_STORE_POP) ? top_r : rel_addr(top_r, OP_IDX_I);
                    pend_nxt = FRS_PEND_STORE;
                    pfmt_nxt = OP_FMT_I;
                    if (OP_CODE_I == FRS_OP_STORE_POP) begin
                        top_nxt = top_r + 3'h1;
                        tag_nxt[top_r] = 1'b0;
                        if (!tag_r[top_r]) begin
                            flt_nxt = 1'b1;
                            stat_nxt[FRS_IE_BIT] = 1'b1;
                            stat_nxt[FRS_SF_BIT] = 1'b1;
                            stat_nxt[FRS_C1_BIT] = 1'b0;
                        end
                    end
                end
                FRS_OP_EXCH: begin
                    pend_nxt = FRS_PEND_EXCH;
                    pfmt_nxt = OP_IDX_I;
                end
                FRS_OP_MMX_WRITE: begin
                    we_a = 1'b1; // absolute alias, exponent forced to ones
                    wa_a = OP_IDX_I;
                    wd_a = {16'hffff, OP_DATA_I[FRS_MMX_W-1:0]};
                    top_nxt = FRS_TOP_RST;
                    tag_nxt = 8'hff;
                end
                FRS_OP_INIT: begin
                    top_nxt  = FRS_TOP_RST;
                    tag_nxt  = FRS_TAG_RST;
                    stat_nxt = FRS_STAT_RST;
                end
                FRS_OP_CLEAR_EXC: stat_nxt = FRS_STAT_RST;
                default:          top_nxt  = top_r; // call and return leave pointer, tags and status alone
            endcase
            stat_nxt[FRS_ES_BIT] = stat_nxt[FRS_IE_BIT];
            stat_nxt[FRS_B_BIT]  = stat_nxt[FRS_IE_BIT];
        end
    end
    // only core-supplied operations reach this state
    always_ff @(posedge CORE_CLK_I) begin
        if (!RSTN_I) begin
            top_r  <= FRS_TOP_RST;
            tag_r  <= FRS_TAG_RST;
            stat_r <= FRS_STAT_RST;
            ip_r   <= 48'h0;
            dp_r   <= 48'h0;
            opc_r  <= 11'h0;
            sv_r   <= 1'b0;
            flt_r  <= 1'b0;
            pend_r <= FRS_PEND_IDLE;
            pfmt_r <= 3'h0;
            sd_r   <= 80'h0;
        end else begin
            top_r  <= top_nxt;
            tag_r  <= tag_nxt;
            stat_r <= stat_nxt;
            ip_r   <= ip_nxt;
            dp_r   <= dp_nxt;
            opc_r  <= opc_nxt;
            sv_r   <= sv_nxt;
            flt_r  <= flt_nxt;
            pend_r <= pend_nxt;
            pfmt_r <= pfmt_nxt;
            sd_r   <= sd_nxt;
        end
    end
    assign STORE_DATA_O  = sd_r;
    assign STORE_VALID_O = sv_r;
    assign STACK_FAULT_O = flt_r;
    assign STATUS_WORD_O = {stat_r[15:14], top_r, stat_r[10:0]};
    assign CTRL_WORD_O   = FRS_CTRL_RST;
    assign TAG_BITS_O    = tag_r;
    assign LAST_IP_O     = ip_r;
    assign LAST_DP_O     = dp_r;
    assign LAST_OPCODE_O = opc_r;
    assign REL_DATA_O    = rd_b; // registered inside the memory
endmodule // frs_stack
`default_nettype wire

// ---- frs_stack_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module frs_stack_monitor
    import frs_pkg::*;
(
    input wire logic        CORE_CLK_I,
    input wire logic        RSTN_I,
    input wire logic        OP_VALID_I,
    input wire logic [3:0]  OP_CODE_I,
    input wire logic        STORE_VALID_O,
    input wire logic        STACK_FAULT_O,
    input wire logic [15:0] STATUS_WORD_O,
    input wire logic [7:0]  TAG_BITS_O
);
    logic       busy_r;
    logic       busy_nxt;
    logic       take;
    logic       st;
    logic       keep;
    logic       push;
    logic       pop;
    logic       flt;
    logic [2:0] top;
    // the cycle after a store or exchange take is swallowed, so it is no take
    always_comb begin
        top = STATUS_WORD_O[FRS_TOP_LSB+:3];
        take = OP_VALID_I && !busy_r;
        st = take && OP_CODE_I inside {FRS_OP_STORE_POP, FRS_OP_STORE_KEEP};
        keep = take && OP_CODE_I inside {FRS_OP_LOAD_KEEP, FRS_OP_STORE_KEEP, FRS_OP_CALL_RET};
        push = take && OP_CODE_I == FRS_OP_LOAD_PUSH;
        pop = take && OP_CODE_I == FRS_OP_STORE_POP;
        flt = (push && TAG_BITS_O[top-3'h1]) || (pop && !TAG_BITS_O[top]);
        busy_nxt = RSTN_I && (st || (take && OP_CODE_I == FRS_OP_EXCH));
    end
    always_ff @(posedge CORE_CLK_I) begin
        busy_r <= busy_nxt;
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    a_store_lat: assert property (st && !flt |-> ##2 STORE_VALID_O)
        else $error("store strobe late");
    a_store_cause: assert property (STORE_VALID_O |-> $past(st, 2))
        else $error("stray store strobe");
    a_push_dec: assert property (push && !flt |=> top == $past(top) - 3'h1)
        else $error("push pointer wrong");
    a_pop_inc: assert property (pop && !flt |=> top == $past(top) + 3'h1)
        else $error("pop pointer wrong");
    a_keep_top: assert property (keep |=> $stable(top))
        else $error("pointer moved");
    a_ovf_flag: assert property (push && flt |=> STACK_FAULT_O && STATUS_WORD_O[FRS_C1_BIT])
        else $error("overflow not flagged");
    a_unf_flag: assert property (pop && flt |=> STACK_FAULT_O && !STATUS_WORD_O[FRS_C1_BIT])
        else $error("underflow not flagged");
    a_fault_cause: assert property (STACK_FAULT_O |-> $past(flt))
        else $error("stray stack fault");
    a_init_top: assert property (take && OP_CODE_I == FRS_OP_INIT |=> top == 3'h0)
        else $error("init pointer not zero");
    a_alias_tags: assert property (take && OP_CODE_I == FRS_OP_MMX_WRITE |=> TAG_BITS_O == 8'hff)
        else $error("alias tags not full");
endmodule // frs_stack_monitor
bind frs_stack frs_stack_monitor frs_stack_monitor_i (
    .CORE_CLK_I, .RSTN_I, .OP_VALID_I, .OP_CODE_I, .STORE_VALID_O,
    .STACK_FAULT_O, .STATUS_WORD_O, .TAG_BITS_O
);
`default_nettype wire

// ---- frs_issue_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module frs_issue_model
    import frs_pkg::*;
(
    input  wire logic   clk_i,
    output logic        valid_o,
    output logic [3:0]  code_o,
    output logic [2:0]  fmt_o,
    output logic [2:0]  idx_o,
    output logic [79:0] data_o,
    output logic [10:0] opcode_o,
    output logic [47:0] ip_o,
    output logic [47:0] dp_o
);
    logic [47:0] seq = 48'h0;
    initial {valid_o, code_o, fmt_o, idx_o, data_o, opcode_o, ip_o, dp_o} = '0;
    // one op per slot from the core's own stream; the idle slot after
    // each op also covers the swallowed cycle after a store or exchange
    task automatic issue(input frs_op_t op, input frs_fmt_t f, input logic [2:0] i, input logic [79:0] d);
        @(posedge clk_i);
        #1;
        seq = seq + 48'h1;
        {valid_o, code_o, fmt_o, idx_o, data_o} = {1'b1, op, f, i, d};
        {opcode_o, ip_o, dp_o} = {seq[10:0], seq, ~seq};
        @(posedge clk_i);
        #1;
        valid_o = 1'b0;
        data_o = ~d; // no stale load value once released
    endtask
endmodule // frs_issue_model
`default_nettype wire

// ---- frs_stack_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module frs_stack_bench
    import frs_pkg::*;
();
    typedef struct packed {
        frs_fmt_t    lf;
        logic [79:0] ld;
        frs_fmt_t    sf;
        logic [79:0] sd;
    } frs_row_t;
    localparam logic [79:0] va = 80'h3fff8000000000000000;
    localparam logic [79:0] vb = 80'h4000c000000000000000;
    localparam logic [79:0] vc = 80'hbfff8000000000000000;
    localparam logic [79:0] mm = 80'h0123456789abcdef;
    frs_row_t rows [6] = '{
        '{FRS_FMT_EXT, va, FRS_FMT_EXT, va},
        '{FRS_FMT_DBL, 80'h3ff0000000000000, FRS_FMT_EXT, va},
        '{FRS_FMT_INT64, 80'h3, FRS_FMT_DBL, 80'h4008000000000000},
        '{FRS_FMT_BCD, 80'h25, FRS_FMT_INT64, 80'h19},
        '{FRS_FMT_EXT, 80'h4000a000000000000000, FRS_FMT_BCD, 80'h2},
        '{FRS_FMT_INT64, 80'h7, FRS_FMT_INT64, 80'h7}};
    logic        clk, rstn, vld, svld, flt;
    logic [3:0]  code;
    logic [2:0]  fmt, idx, top;
    logic [79:0] din, sdat, rel;
    logic [10:0] opc, lopc;
    logic [47:0] ip, dp, lip, ldp;
    logic [15:0] stat, ctrl;
    logic [7:0]  tags;
    int          err_total = 0;
    int          compares = 0;
    int          cyc = 0;
    frs_issue_model frs_issue_model_i (.clk_i(clk), .valid_o(vld), .code_o(code), .fmt_o(fmt), .idx_o(idx),
        .data_o(din), .opcode_o(opc), .ip_o(ip), .dp_o(dp));
    frs_stack frs_stack_i (.CORE_CLK_I(clk), .RSTN_I(rstn), .OP_VALID_I(vld), .OP_CODE_I(code),
        .OP_FMT_I(fmt), .OP_IDX_I(idx), .OP_DATA_I(din), .OP_OPCODE_I(opc), .OP_IP_I(ip), .OP_DP_I(dp),
        .STORE_DATA_O(sdat), .STORE_VALID_O(svld), .STACK_FAULT_O(flt), .STATUS_WORD_O(stat),
        .CTRL_WORD_O(ctrl), .TAG_BITS_O(tags), .LAST_IP_O(lip), .LAST_DP_O(ldp),
        .LAST_OPCODE_O(lopc), .REL_DATA_O(rel));
    assign top = stat[FRS_TOP_LSB+:3];
    // narrow store formats only define the low 64 bits
    function automatic logic [79:0] low(input logic [2:0] f, input logic [79:0] v);
        return (f == FRS_FMT_DBL || f == FRS_FMT_INT64) ? {16'h0, v[63:0]} : v;
    endfunction
    task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic iss(input frs_op_t o, input logic [2:0] i = 3'h0, input logic [79:0] d = 80'h0);
        frs_issue_model_i.issue(o, FRS_FMT_EXT, i, d);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        check(top, 0, "reset pointer");
        check(tags, 0, "reset tags");
        check(ctrl, FRS_CTRL_RST, "control");
        $display("reset test done");
        foreach (rows[n]) begin
            frs_issue_model_i.issue(FRS_OP_LOAD_PUSH, rows[n].lf, 3'h0, rows[n].ld);
            check(top, 7, "push wrap");
            frs_issue_model_i.issue(FRS_OP_STORE_POP, rows[n].sf, 3'h0, 80'h0);
            check(top, 0, "pop pointer");
            @(posedge clk);
            #1;
            check(svld, 1, "store strobe");
            check(low(rows[n].sf, sdat), rows[n].sd, "store value");
            $display("row %0d done", n);
        end
        iss(FRS_OP_STORE_POP);
        check(flt, 1, "underflow");
        check({stat[FRS_C1_BIT], stat[FRS_SF_BIT]}, 2'b01, "underflow flags");
        @(posedge clk);
        iss(FRS_OP_INIT);
        check(stat, 0, "init status");
        $display("underflow test done");
        iss(FRS_OP_LOAD_PUSH, 3'h0, va);
        iss(FRS_OP_LOAD_PUSH, 3'h0, vb);
        check(tags, 8'hc0, "absolute tags");
        iss(FRS_OP_CALL_RET, 3'h1);
        check(rel, va, "index one");
        check(top, 6, "call pointer");
        check(lopc, opc, "last opcode");
        check(lip, ip, "last instruction pointer");
        check(ldp, dp, "last operand pointer");
        iss(FRS_OP_EXCH, 3'h1);
        @(posedge clk);
        iss(FRS_OP_CALL_RET, 3'h0);
        check(rel, va, "swapped head");
        iss(FRS_OP_CALL_RET, 3'h1);
        check(rel, vb, "swapped entry");
        iss(FRS_OP_STORE_KEEP);
        check(top, 6, "keep store");
        @(posedge clk);
        #1;
        check(sdat, va, "keep store value");
        iss(FRS_OP_LOAD_KEEP, 3'h0, vc);
        check(top, 6, "keep load");
        iss(FRS_OP_STORE_POP);
        check(top, 7, "pop");
        @(posedge clk);
        #1;
        check(sdat, vc, "pop value");
        iss(FRS_OP_CALL_RET, 3'h7);
        check(rel, vc, "index seven");
        $display("relative test done");
        repeat (7) iss(FRS_OP_LOAD_PUSH, 3'h0, va);
        check(tags, 8'hff, "full");
        iss(FRS_OP_LOAD_PUSH, 3'h0, vb);
        check(flt, 1, "overflow");
        check(stat[FRS_C1_BIT], 1, "overflow flag");
        iss(FRS_OP_CLEAR_EXC);
        check(stat[FRS_SF_BIT], 0, "cleared");
        iss(FRS_OP_MMX_WRITE, 3'h3, mm);
        check({top, tags}, 11'h0ff, "alias state");
        iss(FRS_OP_CALL_RET, 3'h3);
        check(rel[63:0], mm[63:0], "alias data");
        $display("overflow and alias test done");
        iss(FRS_OP_LOAD_PUSH, 3'h0, vb);
        check(flt, 1, "alias overflow");
        rstn = 1'b0;
        @(posedge clk);
        #1;
        rstn = 1'b1;
        check({top, tags, flt, svld}, 13'h0, "mid-run reset");
        check(stat, 0, "mid-run reset status");
        iss(FRS_OP_LOAD_PUSH, 3'h0, vc);
        iss(FRS_OP_WRITE_REL, 3'h2, va);
        check({top, tags}, 11'h782, "write relative");
        iss(FRS_OP_CALL_RET, 3'h2);
        check(rel, va, "relative written");
        $display("mid-run reset test done");
        complete_run();
    end
endmodule // frs_stack_bench
`default_nettype wire
